// >>> rtl/pma_pkg.sv
`default_nettype none
package pma_pkg;
  localparam int NUM_MC     = 10;
  localparam int NUM_DED    = 12;
  localparam int NUM_IN     = 22;
  localparam int NUM_LIT    = 44;
  localparam int NUM_PAIRS  = 5;
  localparam int BASE_TERMS = 8;
  localparam int TERM_STEP  = 2;
  localparam int NUM_SPARE  = 4;
  localparam int NUM_TERMS  = 136;
  localparam int TERM_CLEAR = 130;
  localparam int TERM_PRESET = 131;
  localparam int TERM_SPARE0 = 132;
  localparam int TOP_FIRST  = 0;
  localparam int BOT_FIRST  = 5;

  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_MC_CFG  = 8'h04;
  localparam logic [7:0] ADDR_TERM_IX = 8'h08;
  localparam logic [7:0] ADDR_TERM_LO = 8'h0C;
  localparam logic [7:0] ADDR_TERM_HI = 8'h10;
  localparam logic [7:0] ADDR_PRELOAD = 8'h14;
  localparam logic [7:0] ADDR_STATE   = 8'h18;
  localparam logic [7:0] ADDR_TESTST  = 8'h1C;

  localparam logic [7:0]  TERM_COUNT_B = 8'h88;
  localparam logic [43:0] TERM_ERASED  = 44'hFFF_FFFF_FFFF;
  localparam logic [19:0] MC_CFG_RST   = 20'h0_0000;
  localparam logic [7:0]  TERM_IX_RST  = 8'h00;

  typedef enum logic [1:0] {
    PMA_RUN    = 2'b00,
    PMA_TOP    = 2'b01,
    PMA_BOTTOM = 2'b10
  } pma_test_e;

  typedef struct packed {
    logic comb_mode_select_bit;
    logic output_polarity_bit;
  } pma_cfg_s;

  typedef struct packed {
    logic dev_en;
    logic preset;
    logic clear;
    logic preload;
  } pma_ctl_s;

  function automatic int terms_of(input int m);
    terms_of = BASE_TERMS + TERM_STEP * (m / 2);
  endfunction

  function automatic int term_base(input int m);
    int acc;
    acc = 0;
    for (int k = 0; k < m; k++) begin
      acc = acc + 1 + terms_of(k);
    end
    term_base = acc;
  endfunction
endpackage
`default_nettype wire

// >>> rtl/pma_macrocell.sv
`default_nettype none
module pma_macrocell (
  input  wire logic              clock,
  input  wire logic              rst_b,
  input  wire pma_pkg::pma_ctl_s ctl,
  input  wire pma_pkg::pma_cfg_s cfg,
  input  wire logic              sum,
  input  wire logic              oe_term,
  input  wire logic              preload_val,
  input  wire logic              pin_sync,
  output logic                   state,
  output logic                   pin_out,
  output logic                   pin_oe,
  output logic                   feedback
);
  logic state_r, state_nxt;
  logic comb_r, comb_nxt;
  logic pin_r, pin_nxt;
  logic oe_r, oe_nxt;
  logic value;

  always_comb begin
    state_nxt = state_r;
    if (ctl.clear) begin
      state_nxt = 1'b0;
    end else if (ctl.preload) begin
      state_nxt = preload_val;
    end else if (ctl.dev_en) begin
      state_nxt = ctl.preset ? 1'b1 : sum;
    end
    comb_nxt = sum;
    value    = cfg.comb_mode_select_bit ? sum : state_nxt;
    pin_nxt  = cfg.output_polarity_bit ? value : ~value;
    oe_nxt   = oe_term;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= 1'b0;
      comb_r  <= 1'b0;
      pin_r   <= 1'b0;
      oe_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      comb_r  <= comb_nxt;
      pin_r   <= pin_nxt;
      oe_r    <= oe_nxt;
    end
  end

  // comb path feeds back its registered copy while driving, else the synchronised pin, so the array never loops on itself
  assign feedback = cfg.comb_mode_select_bit ? (oe_r ? comb_r : pin_sync)
                                             : state_r;
  assign state   = state_r;
  assign pin_out = pin_r;
  assign pin_oe  = oe_r;
endmodule
`default_nettype wire

// >>> rtl/pma_macrocell_array.sv
// Decided for this implementation: the APB slave port and the register addresses.
`default_nettype none
module pma_macrocell_array (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [11:0] ded_in,
  input  wire logic        dev_clk_pin,
  input  wire logic [9:0]  io_in,
  output logic [9:0]       io_out,
  output logic [9:0]       io_oe
);
  localparam int NSYNC = pma_pkg::NUM_DED + pma_pkg::NUM_MC + 1;

  // pin synchronisers
  logic [NSYNC-1:0] sync1_r, sync1_nxt;
  logic [NSYNC-1:0] sync2_r, sync2_nxt;
  logic             dclk_prev_r, dclk_prev_nxt;
  logic [11:0]      ded_s;
  logic [9:0]       io_s;
  logic             dclk_s;
  logic             dev_en;

  always_comb begin
    sync1_nxt     = {dev_clk_pin, io_in, ded_in};
    sync2_nxt     = sync1_r;
    dclk_prev_nxt = dclk_s;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r     <= '0;
      sync2_r     <= '0;
      dclk_prev_r <= 1'b0;
    end else begin
      sync1_r     <= sync1_nxt;
      sync2_r     <= sync2_nxt;
      dclk_prev_r <= dclk_prev_nxt;
    end
  end

  assign ded_s  = sync2_r[11:0];
  assign io_s   = sync2_r[21:12];
  assign dclk_s = sync2_r[22];
  assign dev_en = dclk_s & ~dclk_prev_r;

  // register file state
  pma_pkg::pma_test_e test_r, test_nxt;
  pma_pkg::pma_cfg_s [9:0] cfg_r, cfg_nxt;
  logic [7:0]  ix_r, ix_nxt;
  logic [43:0] mem_r [pma_pkg::NUM_TERMS];
  logic [43:0] mem_nxt [pma_pkg::NUM_TERMS];
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;

  logic        wr_go;
  logic        ix_ok;
  logic [43:0] cur_term;
  logic        preload_go;

  // array
  logic [21:0] arr_in;
  logic [43:0] lit;
  logic [pma_pkg::NUM_TERMS-1:0] hit;
  logic [9:0]  raw_sum;
  logic [9:0]  sum_sel;
  logic [9:0]  oe_term;
  logic [9:0]  mc_state;
  logic [9:0]  mc_fb;
  logic [3:0]  spare_hit;
  pma_pkg::pma_ctl_s ctl;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == pma_pkg::ADDR_CTRL)    || (a == pma_pkg::ADDR_MC_CFG)  ||
                 (a == pma_pkg::ADDR_TERM_IX) || (a == pma_pkg::ADDR_TERM_LO) ||
                 (a == pma_pkg::ADDR_TERM_HI) || (a == pma_pkg::ADDR_PRELOAD) ||
                 (a == pma_pkg::ADDR_STATE)   || (a == pma_pkg::ADDR_TESTST);
  endfunction

  assign wr_go      = psel & penable & pready_r & pwrite & addr_known(paddr);
  assign ix_ok      = ix_r < pma_pkg::TERM_COUNT_B;
  assign cur_term   = ix_ok ? mem_r[ix_r] : '0;
  assign preload_go = wr_go & (paddr == pma_pkg::ADDR_PRELOAD);

  always_comb begin
    test_nxt    = test_r;
    cfg_nxt     = cfg_r;
    ix_nxt      = ix_r;
    for (int t = 0; t < pma_pkg::NUM_TERMS; t++) begin
      mem_nxt[t] = mem_r[t];
    end
    prdata_nxt  = prdata_r;
    pready_nxt  = psel & ~penable;
    pslverr_nxt = 1'b0;
    if (psel & ~penable) begin
      pslverr_nxt = ~addr_known(paddr);
      prdata_nxt  = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          pma_pkg::ADDR_CTRL:    prdata_nxt = {30'h0000_0000, test_r};
          pma_pkg::ADDR_MC_CFG:  prdata_nxt = {12'h000, cfg_r};
          pma_pkg::ADDR_TERM_IX: prdata_nxt = {24'h00_0000, ix_r};
          pma_pkg::ADDR_TERM_LO: prdata_nxt = cur_term[31:0];
          pma_pkg::ADDR_TERM_HI: prdata_nxt = {20'h0_0000, cur_term[43:32]};
          pma_pkg::ADDR_STATE:   prdata_nxt = {12'h000, io_oe, mc_state};
          pma_pkg::ADDR_TESTST:  prdata_nxt = {26'h000_0000, hit[pma_pkg::TERM_PRESET],
                                              hit[pma_pkg::TERM_CLEAR], spare_hit};
          default:               prdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    if (wr_go) begin
      case (paddr)
        pma_pkg::ADDR_CTRL: begin
          case (pwdata[1:0])
            2'b01:   test_nxt = pma_pkg::PMA_TOP;
            2'b10:   test_nxt = pma_pkg::PMA_BOTTOM;
            default: test_nxt = pma_pkg::PMA_RUN;
          endcase
        end
        pma_pkg::ADDR_MC_CFG:  cfg_nxt = pwdata[19:0];
        pma_pkg::ADDR_TERM_IX: ix_nxt  = pwdata[7:0];
        pma_pkg::ADDR_TERM_LO: begin
          if (ix_ok) begin
            mem_nxt[ix_r][31:0] = pwdata;
          end
        end
        pma_pkg::ADDR_TERM_HI: begin
          if (ix_ok) begin
            mem_nxt[ix_r][43:32] = pwdata[11:0];
          end
        end
        default: ix_nxt = ix_r;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      test_r    <= pma_pkg::PMA_RUN;
      cfg_r     <= pma_pkg::MC_CFG_RST;
      ix_r      <= pma_pkg::TERM_IX_RST;
      for (int t = 0; t < pma_pkg::NUM_TERMS; t++) begin
        mem_r[t] <= pma_pkg::TERM_ERASED;
      end
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      test_r    <= test_nxt;
      cfg_r     <= cfg_nxt;
      ix_r      <= ix_nxt;
      for (int t = 0; t < pma_pkg::NUM_TERMS; t++) begin
        mem_r[t] <= mem_nxt[t];
      end
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // array inputs: dedicated pins plus one feedback per cell
  assign arr_in = {mc_fb, ded_s};
  assign lit    = {~arr_in, arr_in};

  // an erased term has every literal and its complement connected, so it never fires
  genvar t;
  generate
    for (t = 0; t < pma_pkg::NUM_TERMS; t++) begin : g_term
      assign hit[t] = &(~mem_r[t] | lit);
    end
  endgenerate

  assign spare_hit = hit[pma_pkg::TERM_SPARE0 +: pma_pkg::NUM_SPARE];

  genvar m;
  generate
    for (m = 0; m < pma_pkg::NUM_MC; m++) begin : g_sum
      localparam int BASE = pma_pkg::term_base(m);
      localparam int CNT  = pma_pkg::terms_of(m);
      assign oe_term[m] = hit[BASE];
      assign raw_sum[m] = |hit[BASE+1 +: CNT];
    end
  endgenerate

  // test modes swap one half's sums for the spare terms; user terms stay untouched
  always_comb begin
    sum_sel = raw_sum;
    for (int k = 0; k < pma_pkg::NUM_PAIRS; k++) begin
      if (test_r == pma_pkg::PMA_TOP) begin
        sum_sel[pma_pkg::TOP_FIRST + k] = spare_hit[k % pma_pkg::NUM_SPARE];
      end else if (test_r == pma_pkg::PMA_BOTTOM) begin
        sum_sel[pma_pkg::BOT_FIRST + k] = spare_hit[k % pma_pkg::NUM_SPARE];
      end
    end
  end

  // the clear term acts on the next system clock, not waiting for the device clock
  assign ctl.dev_en  = dev_en;
  assign ctl.preset  = hit[pma_pkg::TERM_PRESET];
  assign ctl.clear   = hit[pma_pkg::TERM_CLEAR];
  assign ctl.preload = preload_go;

  generate
    for (m = 0; m < pma_pkg::NUM_MC; m++) begin : g_mc
      pma_macrocell u_mc (
        .clock       (clock),
        .rst_b       (rst_b),
        .ctl         (ctl),
        .cfg         (cfg_r[m]),
        .sum         (sum_sel[m]),
        .oe_term     (oe_term[m]),
        .preload_val (pwdata[m]),
        .pin_sync    (io_s[m]),
        .state       (mc_state[m]),
        .pin_out     (io_out[m]),
        .pin_oe      (io_oe[m]),
        .feedback    (mc_fb[m])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// >>> dv/pma_checker.sv
`default_nettype none
module pma_chk (
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [9:0]  io_out,
  input wire logic [9:0]  io_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic setup;
  assign setup = psel && !penable;
  answer_next_a: assert property (setup |=> pready)
    else $error("no answer after setup");
  answer_single_a: assert property (pready |=> !pready)
    else $error("answer longer than one cycle");
  answer_cause_a: assert property (pready |-> $past(setup))
    else $error("answer without setup");
  error_ready_a: assert property (pslverr |-> pready)
    else $error("error outside answer");
  unmapped_read_a: assert property (setup && !pwrite && paddr > pma_pkg::ADDR_TESTST
    |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  mapped_ok_a: assert property (setup && paddr <= pma_pkg::ADDR_TESTST
    && paddr[1:0] == 2'b00 |=> !pslverr)
    else $error("mapped access refused");
  data_hold_a: assert property (!setup |=> $stable(prdata))
    else $error("read data moved without setup");
  reset_level_a: assert property ($rose(rst_b) |=> io_out == 10'h3FF && io_oe == 10'h000)
    else $error("pins wrong after reset");
endmodule
bind pma_macrocell_array pma_chk i_chk (
  .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .io_out(io_out), .io_oe(io_oe)
);
`default_nettype wire

// >>> dv/pma_board.sv
`default_nettype none
module pma_board (
  input  wire logic [9:0] io_out,
  input  wire logic [9:0] io_oe,
  input  wire logic [9:0] drv,
  output logic [9:0]      io_in
);
  // board only drives a pin the cell has let go, so no contention is modelled
  assign io_in = (io_oe & io_out) | (~io_oe & drv);
endmodule
`default_nettype wire

// >>> dv/test_programmable_macrocell_array.sv
`default_nettype none
module test_programmable_macrocell_array;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, dclk = 1'b0, pready, pslverr, errv;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic [11:0] ded = 12'h000;
  logic [9:0]  drv = 10'h000, io_in, io_out, io_oe;
  int          failures = 0, checked = 0;
  always #20 clock = ~clock;
  pma_macrocell_array i_dut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ded_in(ded), .dev_clk_pin(dclk), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe));
  pma_board i_board (.io_out(io_out), .io_oe(io_oe), .drv(drv), .io_in(io_in));
  task automatic end_of_test;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // pready, read data and error are taken at the rising edge that ends the access,
  // the same edge at which a write lands; only then is the request released
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdv = prdata;
    errv = pslverr;
    if (pready !== 1'b1) begin
      failures++;
      end_of_test;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask
  task automatic term(input logic [7:0] ix, input logic [43:0] v);
    apb(1'b1, pma_pkg::ADDR_TERM_IX, {24'h0, ix});
    apb(1'b1, pma_pkg::ADDR_TERM_LO, v[31:0]);
    apb(1'b1, pma_pkg::ADDR_TERM_HI, {20'h0, v[43:32]});
  endtask
  task automatic dpulse;
    dclk <= 1'b1;
    repeat (3) @(posedge clock);
    dclk <= 1'b0;
    repeat (3) @(posedge clock);
  endtask
  task automatic wpin(input int i, input logic v);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (io_out[i] !== v && n < 20);
    chk({31'h0, io_out[i]}, {31'h0, v});
    @(posedge clock);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    @(negedge clock);
    chk({22'h0, io_out}, 32'h3FF);
    chk({22'h0, io_oe}, 32'h0);
    @(posedge clock);
    rd(pma_pkg::ADDR_MC_CFG, 32'h0);
    rd(pma_pkg::ADDR_STATE, 32'h0);
    rd(pma_pkg::ADDR_TESTST, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, errv}, 32'h1);
    term(8'd0, 44'h0);
    term(8'd1, 44'h1);
    ded <= 12'h001;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, pma_pkg::ADDR_MC_CFG, 32'(c));
      dpulse;
      wpin(0, c[0]);
    end
    ded <= 12'h000;
    wpin(0, 1'b0);
    term(8'd132, 44'h0);
    rd(pma_pkg::ADDR_TESTST, 32'h1);
    apb(1'b1, pma_pkg::ADDR_CTRL, 32'h1);
    wpin(0, 1'b1);
    apb(1'b1, pma_pkg::ADDR_CTRL, 32'h2);
    wpin(0, 1'b0);
    rd(pma_pkg::ADDR_CTRL, 32'h2);
    apb(1'b1, pma_pkg::ADDR_CTRL, 32'h3);
    rd(pma_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, pma_pkg::ADDR_CTRL, 32'h0);
    // cell 1 inverts its own fed-back state on every device clock
    term(8'd9, 44'h0);
    term(8'd10, 44'h8_0000_0000);
    apb(1'b1, pma_pkg::ADDR_MC_CFG, 32'h5);
    for (int k = 0; k < 3; k++) begin
      dpulse;
      rd(pma_pkg::ADDR_STATE, (k % 2 == 0) ? 32'hC02 : 32'hC00);
    end
    apb(1'b1, pma_pkg::ADDR_PRELOAD, 32'h3FF);
    rd(pma_pkg::ADDR_STATE, 32'hFFF);
    term(8'd130, 44'h0);
    rd(pma_pkg::ADDR_STATE, 32'hC00);
    term(8'd130, pma_pkg::TERM_ERASED);
    term(8'd131, 44'h0);
    rd(pma_pkg::ADDR_STATE, 32'hC00);
    dpulse;
    rd(pma_pkg::ADDR_STATE, 32'hFFF);
    rd(pma_pkg::ADDR_TESTST, 32'h21);
    apb(1'b1, pma_pkg::ADDR_STATE, 32'h0);
    rd(pma_pkg::ADDR_STATE, 32'hFFF);
    term(8'd131, pma_pkg::TERM_ERASED);
    rd(pma_pkg::ADDR_TERM_LO, pma_pkg::TERM_ERASED[31:0]);
    rd(pma_pkg::ADDR_TERM_HI, {20'h0_0000, pma_pkg::TERM_ERASED[43:32]});
    // an index past the last term reads zero and takes no write
    apb(1'b1, pma_pkg::ADDR_TERM_IX, 32'h0000_00C8);
    apb(1'b1, pma_pkg::ADDR_TERM_LO, 32'h0000_0000);
    rd(pma_pkg::ADDR_TERM_LO, 32'h0);
    rd(pma_pkg::ADDR_TERM_IX, 32'hC8);
    // pin 2 is released and driven by the board; cell 3 copies its feedback
    term(8'd29, 44'h0);
    term(8'd30, 44'h4000);
    apb(1'b1, pma_pkg::ADDR_MC_CFG, 32'hF5);
    drv <= 10'h004;
    wpin(3, 1'b1);
    drv <= 10'h000;
    wpin(3, 1'b0);
    end_of_test;
  end
endmodule
`default_nettype wire
